/* File: core/frc_top.sv */
// Purpose: flash controller register set and read wait-state sequencer
// Assumes: single CORE_CLK domain, APB slave, one-cycle access phase
// Notes: flash read requests arrive from same-clock fabric logic
// Notes: read data and error are prepared in the setup cycle
`timescale 1ns/1ps
`default_nettype none
module frc_top
    import frc_pkg::*;
#(
    parameter int LP_WIDTH = 5
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // flash read port
    input wire logic RD_REQ,
    input wire logic [23:0] RD_ADDR,
    output logic RD_BUSY,
    output logic RD_DONE,
    output logic RD_LOW_POWER,
    output logic [4:0] RD_WAIT_ACTIVE
);
    typedef struct packed {
        logic [31:0] op_control;
        logic [31:0] unlock_key;
        logic [31:0] target_addr;
        logic [31:0] data0;
        logic [31:0] data1;
        logic [31:0] data2;
        logic [31:0] data3;
        logic [31:0] row_src;
        logic [31:0] prog_wp;
        logic [31:0] boot_wp;
        logic [31:0] read_control;
        logic [31:0] cache_control;
        frc_key_e key;
        frc_rd_e rd;
        logic [4:0] wait_cnt;
        logic [4:0] wait_lat;
        logic low_pwr;
        logic busy;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic done;
    } frc_state_s;

    frc_state_s q;
    frc_state_s next_q;

    logic [31:0] old_val;
    logic [31:0] new_val;
    logic [31:0] mask;
    logic alias_ok;
    logic hit;
    logic [11:0] base;
    logic [3:0] sub;
    logic [4:0] wait_sel;
    logic same_panel;
    logic wr;
    logic setup;

    // combine a stored value with a write through the alias kind
    function automatic logic [31:0] apply_alias(
        input logic [31:0] cur,
        input logic [31:0] wdata,
        input logic [3:0] kind
    );
        logic [31:0] res;
        res = wdata;
        case (kind)
            SUB_CLR: res = cur & ~wdata;
            SUB_SET: res = cur | wdata;
            SUB_INV: res = cur ^ wdata;
            default: res = wdata;
        endcase
        return res;
    endfunction

    always_comb begin
        next_q = q;
        // base picks the register, sub the alias kind
        base = {PADDR[11:4], 4'h0};
        sub = PADDR[3:0];
        // a transfer counts only at the edge where PREADY stands high
        wr = PSEL && PENABLE && PWRITE && q.pready;
        setup = PSEL && !PENABLE;
        hit = 1'b1;
        alias_ok = 1'b0;
        old_val = RST_ZERO;
        mask = RST_ZERO;
        new_val = RST_ZERO;
        next_q.pslverr = 1'b0;
        next_q.done = 1'b0;
        case (base)
            OFS_OP_CONTROL: begin
                old_val = q.op_control;
                mask = MASK_OP_CONTROL;
                alias_ok = 1'b1;
            end
            OFS_UNLOCK_KEY: begin
                old_val = q.unlock_key;
                mask = '1;
            end
            OFS_TARGET_ADDR: begin
                old_val = q.target_addr;
                mask = '1;
                alias_ok = 1'b1;
            end
            OFS_WRITE_DATA0: begin
                old_val = q.data0;
                mask = '1;
            end
            OFS_WRITE_DATA1: begin
                old_val = q.data1;
                mask = '1;
            end
            OFS_WRITE_DATA2: begin
                old_val = q.data2;
                mask = '1;
            end
            OFS_WRITE_DATA3: begin
                old_val = q.data3;
                mask = '1;
            end
            OFS_ROW_SRC_ADDR: begin
                old_val = q.row_src;
                mask = '1;
            end
            OFS_PROG_WP: begin
                old_val = q.prog_wp;
                mask = MASK_PROG_WP;
                alias_ok = 1'b1;
            end
            OFS_BOOT_WP: begin
                old_val = q.boot_wp;
                mask = MASK_BOOT_WP;
                alias_ok = 1'b1;
            end
            OFS_READ_CONTROL: begin
                old_val = q.read_control;
                mask = MASK_READ_CONTROL;
                alias_ok = 1'b1;
            end
            OFS_CACHE_CONTROL: begin
                old_val = q.cache_control;
                mask = MASK_CACHE_CONTROL;
            end
            default: hit = 1'b0;
        endcase

        // aliases exist only where listed; the key register has none
        if (sub != SUB_PLAIN && !alias_ok) begin
            hit = 1'b0;
        end
        // byte offsets inside a word are refused, not rounded down
        if (sub[1:0] != 2'b00) begin
            hit = 1'b0;
        end

        new_val = apply_alias(old_val, PWDATA, sub);
        // keep unimplemented bits at their stored value
        new_val = (new_val & mask) | (old_val & ~mask);

        // answer is prepared in setup so that it stands at the access edge
        next_q.pready = setup;
        if (setup) begin
            next_q.pslverr = !hit;
            if (!PWRITE) begin
                next_q.prdata = hit ? old_val : RST_ZERO;
            end
        end

        if (wr) begin
            if (hit) begin
                case (base)
                    OFS_OP_CONTROL: next_q.op_control = new_val;
                    OFS_UNLOCK_KEY: next_q.unlock_key = new_val;
                    OFS_TARGET_ADDR: next_q.target_addr = new_val;
                    OFS_WRITE_DATA0: next_q.data0 = new_val;
                    OFS_WRITE_DATA1: next_q.data1 = new_val;
                    OFS_WRITE_DATA2: next_q.data2 = new_val;
                    OFS_WRITE_DATA3: next_q.data3 = new_val;
                    OFS_ROW_SRC_ADDR: next_q.row_src = new_val;
                    OFS_PROG_WP: next_q.prog_wp = new_val;
                    OFS_BOOT_WP: next_q.boot_wp = new_val;
                    OFS_READ_CONTROL: begin
                        // erase tally is plain storage
                        if (q.op_control[POS_WRITE_ENABLE] ||
                            q.key != KEY_OPEN) begin
                            new_val = (new_val & ~MASK_READ_LOCKED) |
                                (q.read_control & MASK_READ_LOCKED);
                        end
                        next_q.read_control = new_val;
                    end
                    OFS_CACHE_CONTROL: next_q.cache_control = new_val;
                    default: hit = 1'b0;
                endcase
            end
        end

        // unlock sequence: two key words back to back, then one write
        if (wr && hit && base == OFS_UNLOCK_KEY) begin
            if (PWDATA == KEY_FIRST) begin
                next_q.key = KEY_HALF;
            end else if (PWDATA == KEY_SECOND && q.key == KEY_HALF) begin
                next_q.key = KEY_OPEN;
            end else begin
                next_q.key = KEY_IDLE;
            end
        end else if (wr && hit && base == OFS_READ_CONTROL) begin
            next_q.key = KEY_IDLE;
        end else if (wr && q.key == KEY_HALF) begin
            next_q.key = KEY_IDLE;
        end

        // wait source: low power count, zero on another panel, or cache field
        // the panel test matters only while verify read is set
        same_panel = (RD_ADDR / PANEL_SIZE_BYTES) ==
            (q.target_addr[23:0] / PANEL_SIZE_BYTES);
        if (q.read_control[POS_LP_SELECT]) begin
            wait_sel = q.read_control[POS_LP_COUNT +: LP_WIDTH];
        end else if (q.read_control[POS_VERIFY_READ] && !same_panel) begin
            wait_sel = 5'h00;
        end else begin
            wait_sel = {2'b00, q.cache_control[POS_CACHE_WAIT +: 3]};
        end
        case (q.rd)
            RD_IDLE: begin
                if (RD_REQ) begin
                    // latch source only at read start
                    next_q.wait_lat = wait_sel;
                    next_q.low_pwr = q.read_control[POS_LP_SELECT];
                    next_q.wait_cnt = wait_sel;
                    if (wait_sel == 5'h00) begin
                        next_q.done = 1'b1;
                    end else begin
                        next_q.rd = frc_pkg::RD_BUSY;
                        next_q.busy = 1'b1;
                    end
                end
            end
            // a request while busy is dropped, not queued
            frc_pkg::RD_BUSY: begin
                next_q.wait_cnt = q.wait_cnt - 5'h01;
                if (q.wait_cnt == 5'h01) begin
                    next_q.done = 1'b1;
                    next_q.rd = RD_IDLE;
                    next_q.busy = 1'b0;
                end
            end
            default: begin
                next_q.rd = RD_IDLE;
                next_q.busy = 1'b0;
            end
        endcase
    end

    // write protect and read control leave reset non-zero
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            q <= '0;
            q.prog_wp <= RST_PROG_WP;
            q.boot_wp <= RST_BOOT_WP;
            q.read_control <= RST_READ_CONTROL;
            q.key <= KEY_IDLE;
            q.rd <= RD_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign RD_BUSY = q.busy;
    assign RD_DONE = q.done;
    assign RD_LOW_POWER = q.low_pwr;
    assign RD_WAIT_ACTIVE = q.wait_lat;
endmodule
`default_nettype wire

/* File: inc/frc_pkg.sv */
// Purpose: constants and types for the flash read control register block
// Assumes: 32-bit APB, word aligned registers
// Notes: offsets are byte addresses relative to the block base
package frc_pkg;
    localparam logic [11:0] OFS_OP_CONTROL = 12'h0a00;
    localparam logic [11:0] OFS_UNLOCK_KEY = 12'h0a10;
    localparam logic [11:0] OFS_TARGET_ADDR = 12'h0a20;
    localparam logic [11:0] OFS_WRITE_DATA0 = 12'h0a30;
    localparam logic [11:0] OFS_WRITE_DATA1 = 12'h0a40;
    localparam logic [11:0] OFS_WRITE_DATA2 = 12'h0a50;
    localparam logic [11:0] OFS_WRITE_DATA3 = 12'h0a60;
    localparam logic [11:0] OFS_ROW_SRC_ADDR = 12'h0a70;
    localparam logic [11:0] OFS_PROG_WP = 12'h0a80;
    localparam logic [11:0] OFS_BOOT_WP = 12'h0a90;
    localparam logic [11:0] OFS_READ_CONTROL = 12'h0aa0;
    // own choice: cache wait field register
    localparam logic [11:0] OFS_CACHE_CONTROL = 12'h0b00;
    // alias sub-offsets
    localparam logic [3:0] SUB_PLAIN = 4'h0;
    localparam logic [3:0] SUB_CLR = 4'h4;
    localparam logic [3:0] SUB_SET = 4'h8;
    localparam logic [3:0] SUB_INV = 4'hc;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_PROG_WP = 32'h8000_0000;
    localparam logic [31:0] RST_BOOT_WP = 32'h0000_9fdf;
    localparam logic [31:0] RST_READ_CONTROL = 32'h001f_0000;
    // implemented bit masks
    localparam logic [31:0] MASK_OP_CONTROL = 32'h0000_f0cf;
    localparam logic [31:0] MASK_PROG_WP = 32'h80ff_ffff;
    localparam logic [31:0] MASK_BOOT_WP = 32'h0000_9f9f;
    localparam logic [31:0] MASK_READ_CONTROL = 32'hf01f_b3c0;
    localparam logic [31:0] MASK_CACHE_CONTROL = 32'h0000_0007;
    // locked bits of read control: low power select, count, panel reads
    localparam logic [31:0] MASK_READ_LOCKED = 32'h001f_b000;
    // field positions
    localparam int POS_WRITE_ENABLE = 14;
    localparam int POS_LP_SELECT = 15;
    localparam int POS_VERIFY_READ = 12;
    localparam int POS_LP_COUNT = 16;
    localparam int POS_ERASE_TALLY = 28;
    localparam int POS_CACHE_WAIT = 0;
    // unlock key words
    localparam logic [31:0] KEY_FIRST = 32'haa99_6655;
    localparam logic [31:0] KEY_SECOND = 32'h5566_99aa;
    localparam logic [23:0] PANEL_SIZE_BYTES = 24'h04_0000;
    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} frc_key_e;
    typedef enum logic [0:0] {RD_IDLE, RD_BUSY} frc_rd_e;
endpackage

/* File: sim/frc_assertions.sv */
// Purpose: port checks for the flash read control block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to frc_top below
`timescale 1ns/1ps
`default_nettype none
module frc_assertions
    import frc_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // flash read
    input wire logic RD_REQ,
    input wire logic [23:0] RD_ADDR,
    input wire logic RD_BUSY,
    input wire logic RD_DONE,
    input wire logic RD_LOW_POWER,
    input wire logic [4:0] RD_WAIT_ACTIVE
);
    logic [5:0] busy_run;
    logic acc;
    assign acc = PSEL && PENABLE && PREADY;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // counts busy cycles so the span can be tied to the latched count
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_run <= 6'h00;
        end else begin
            busy_run <= RD_BUSY ? busy_run + 6'h01 : 6'h00;
        end
    end
    chk_busy_span: assert property (
        RD_DONE |-> busy_run == {1'b0, RD_WAIT_ACTIVE})
        else $error("busy span differs from wait count");
    chk_wait_hold: assert property (
        RD_BUSY && $past(RD_BUSY) |-> $stable(RD_WAIT_ACTIVE)
        && $stable(RD_LOW_POWER)) else $error("wait count moved mid read");
    chk_busy_end: assert property (
        $fell(RD_BUSY) |-> RD_DONE) else $error("busy ended without done");
    chk_busy_nonzero: assert property (
        $rose(RD_BUSY) |-> RD_WAIT_ACTIVE != 5'h00)
        else $error("busy with zero waits");
    chk_read_taken: assert property (
        RD_REQ && !RD_BUSY |=> RD_BUSY || RD_DONE)
        else $error("read request not taken");
    chk_region_err: assert property (
        acc && PADDR[11:9] != 3'b101 |-> PSLVERR)
        else $error("unmapped access without error");
    chk_key_alias: assert property (
        acc && PADDR[11:4] == OFS_UNLOCK_KEY[11:4] && PADDR[3:0] != 4'h0
        |-> PSLVERR) else $error("key alias accepted");
    chk_unimpl_zero: assert property (
        acc && !PWRITE && PADDR == OFS_READ_CONTROL
        |-> (PRDATA & ~MASK_READ_CONTROL) == 32'h0000_0000)
        else $error("unimplemented bits read nonzero");
endmodule
bind frc_top frc_assertions u_frc_assertions (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR),
    .RD_BUSY(RD_BUSY), .RD_DONE(RD_DONE),
    .RD_LOW_POWER(RD_LOW_POWER), .RD_WAIT_ACTIVE(RD_WAIT_ACTIVE)
);
`default_nettype wire

/* File: sim/test_frc_top.sv */
// Purpose: self-checking bench for the flash read control block
// Assumes: apb answer is taken at the edge where PREADY is high
// Notes: random values from a bench lfsr seeded with 6
`timescale 1ns/1ps
`default_nettype none
module test_frc_top
    import frc_pkg::*;
;
    logic CORE_CLK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, RD_REQ = 1'b0;
    logic PREADY, PSLVERR, RD_BUSY, RD_DONE, RD_LOW_POWER;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, q, rc, c;
    logic [31:0] r = 32'h0000_0006;
    logic [23:0] RD_ADDR = 24'h00_0000;
    logic [4:0] RD_WAIT_ACTIVE;
    logic [3:0] subs [3] = '{SUB_CLR, SUB_SET, SUB_INV};
    int n_errors = 0, checks_done = 0;
    always #20 CORE_CLK = ~CORE_CLK;
    frc_top u_frc_top (
        .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR),
        .RD_BUSY(RD_BUSY), .RD_DONE(RD_DONE),
        .RD_LOW_POWER(RD_LOW_POWER), .RD_WAIT_ACTIVE(RD_WAIT_ACTIVE)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // without unlock only the free bits may move
    function automatic logic [31:0] upd(input logic [31:0] cur, w,
            input logic [3:0] k);
        logic [31:0] n;
        n = k == SUB_CLR ? cur & ~w : k == SUB_SET ? cur | w :
            k == SUB_INV ? cur ^ w : w;
        return (cur & MASK_READ_LOCKED)
            | (n & MASK_READ_CONTROL & ~MASK_READ_LOCKED);
    endfunction
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, x);
        checks_done++;
        if (s !== x) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic xe);
        int k;
        k = 0;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        // answer taken at the completing edge, before anything moves
        q = PRDATA;
        chk({31'h0, PREADY}, 32'h0000_0001);
        chk({31'h0, PSLVERR}, {31'h0, xe});
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, 1'b0);
        chk(q, x);
    endtask
    task automatic unl();
        apb(1'b1, OFS_UNLOCK_KEY, KEY_FIRST, 1'b0);
        apb(1'b1, OFS_UNLOCK_KEY, KEY_SECOND, 1'b0);
    endtask
    task automatic fr(input logic [23:0] a, input logic [4:0] n,
            input logic lp);
        int k;
        k = 0;
        @(posedge CORE_CLK);
        RD_REQ <= 1'b1;
        RD_ADDR <= a;
        @(posedge CORE_CLK);
        RD_REQ <= 1'b0;
        #1 chk({27'h0, RD_WAIT_ACTIVE}, {27'h0, n});
        chk({31'h0, RD_LOW_POWER}, {31'h0, lp});
        chk({31'h0, RD_BUSY}, {31'h0, n != 5'h00});
        while (RD_DONE !== 1'b1 && k < 40) begin
            @(posedge CORE_CLK);
            #1 k++;
        end
        chk(32'(k), {27'h0, n});
    endtask
    initial begin
        repeat (3) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        rc = RST_READ_CONTROL;
        rd(OFS_READ_CONTROL, rc);
        rd(OFS_PROG_WP, RST_PROG_WP);
        rd(OFS_BOOT_WP, RST_BOOT_WP);
        fr(24'h00_1000, 5'h00, 1'b0);
        apb(1'b1, OFS_READ_CONTROL, 32'hffff_ffff, 1'b0);
        rc = upd(rc, 32'hffff_ffff, SUB_PLAIN);
        rd(OFS_READ_CONTROL, rc);
        for (int i = 0; i < 9; i++) begin
            r = lfsr(r);
            apb(1'b1, OFS_READ_CONTROL | {8'h00, subs[i % 3]}, r, 1'b0);
            rc = upd(rc, r, subs[i % 3]);
            rd(OFS_READ_CONTROL, rc);
        end
        apb(1'b1, 12'hffc, r, 1'b1);
        apb(1'b1, OFS_UNLOCK_KEY | {8'h00, SUB_SET}, r, 1'b1);
        for (int i = 0; i < 7; i++) begin
            r = lfsr(r);
            c = i == 0 ? 32'h0 : i == 1 ? 32'h1f : {27'h0, r[4:0]};
            // counts 3, 4 and 5 are the ones software picks by clock rate
            c = i > 1 && i < 5 ? 32'(i + 1) : c;
            unl();
            rc = (rc & ~MASK_READ_LOCKED) | 32'h0000_8000 | (c << 16);
            apb(1'b1, OFS_READ_CONTROL, rc, 1'b0);
            rd(OFS_READ_CONTROL, rc);
            fr(r[23:0], c[4:0], 1'b1);
        end
        apb(1'b1, OFS_OP_CONTROL, 32'h0000_4000, 1'b0);
        unl();
        apb(1'b1, OFS_READ_CONTROL, rc & ~MASK_READ_LOCKED, 1'b0);
        rd(OFS_READ_CONTROL, rc);
        apb(1'b1, OFS_OP_CONTROL, 32'h0, 1'b0);
        c = {29'h0, r[2:0] | 3'h1};
        apb(1'b1, OFS_CACHE_CONTROL, c, 1'b0);
        apb(1'b1, OFS_TARGET_ADDR, 32'h0004_0000, 1'b0);
        unl();
        rc = (rc & ~MASK_READ_LOCKED) | 32'h001f_1000;
        apb(1'b1, OFS_READ_CONTROL, rc, 1'b0);
        fr(24'h04_0010, c[4:0], 1'b0);
        fr(24'h08_0010, 5'h00, 1'b0);
        unl();
        apb(1'b1, OFS_READ_CONTROL, rc & ~32'h0000_1000, 1'b0);
        fr(24'h08_0010, c[4:0], 1'b0);
        stop_test();
    end
    initial begin
        repeat (4000) @(posedge CORE_CLK);
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
